// ==== rtl/fault_mgr_map.vh ====
// Purpose: Constants for the motor driver fault manager.
// Assumes: Included by rtl/motor_driver_fault_manager.v.
// Notes:   Cause index order below is the priority order, lowest wins.
`ifndef FAULT_MGR_MAP_VH
`define FAULT_MGR_MAP_VH
`define NUM_CAUSES        15
// Cause indices.
`define C_OVERHEAT        0
`define C_OVERLOAD        1
`define C_OVERSPEED       2
`define C_PULSE           3
`define C_OVERVOLT        4
`define C_UNDERVOLT       5
`define C_DEV_ON          6
`define C_DEV_OFF         7
`define C_OP_DATA         8
`define C_GEAR            9
`define C_SENSOR_RUN      10
`define C_SENSOR_INIT     11
`define C_ROTOR           12
`define C_COMBO           13
`define C_STORED          14
// Causes that a clear may not remove.
`define NORESET_MASK      15'h7_F30
// Causes that cut motor current.
`define CUT_MASK          15'h7_EFF
// Register map.
`define A_STATUS          4'h0
`define A_MASK            4'h1
`define A_CTRL            4'h2
`define A_OVL_LIMIT       4'h3
`define A_ACTIVE          4'h4
`define A_HIST_CLR        4'h5
`define A_HIST_BASE       4'h6
`define CTRL_CODE_EN      0
`define CTRL_TOOL_CLR     1
`define CTRL_GEARED       2
// Blink timing: on and off phases of 250 ms, gap of 1500 ms.
`define BLINK_MS          250
`define GAP_MS            1500
`define CLK_KHZ           125000
`define OVL_LIMIT_RST     16'h0_3E8
`define HIST_DEPTH        10
`endif

// ==== rtl/blink_counter.v ====
// Purpose: Blinks a lamp a given number of times, then a long gap.
// Assumes: i_count held steady while i_run is high.
// Notes:   Lamp is off whenever i_run is low.
`timescale 1ns/100ps
module blink_counter #(
  parameter PHASE_CYC = 31250000,
  parameter GAP_CYC   = 187500000
) (
  input  wire       i_core_clk,
  input  wire       i_srst,
  input  wire       i_run,
  input  wire [3:0] i_count,
  output reg        o_lamp
);
  reg [27:0] timer_reg;
  reg [4:0]  phase_reg;
  wire       last_phase = (phase_reg == {i_count, 1'b0});
  wire [27:0] limit = last_phase ? GAP_CYC[27:0] - 28'd1
                                 : PHASE_CYC[27:0] - 28'd1;

  // Odd phases light the lamp; the phase after the last blink is the gap.
  always @(posedge i_core_clk) begin
    if (i_srst || !i_run) begin
      timer_reg <= 28'd0;
      phase_reg <= 5'd0;
      o_lamp    <= 1'b0;
    end else if (timer_reg == limit) begin
      timer_reg <= 28'd0;
      phase_reg <= last_phase ? 5'd0 : phase_reg + 5'd1;
      o_lamp    <= !last_phase && !phase_reg[0];
    end else begin
      timer_reg <= timer_reg + 28'd1;
    end
  end
endmodule

// ==== rtl/motor_driver_fault_manager.v ====
// Purpose: Latches driver faults, encodes them, keeps history, clears them.
// Assumes: Detector inputs are synchronous levels; i_srst is power-up.
// Notes:   Registers are word indexed on a 4-bit address.
`timescale 1ns/100ps
`include "fault_mgr_map.vh"
module motor_driver_fault_manager #(
  parameter PHASE_CYC = `BLINK_MS * (`CLK_KHZ),
  parameter GAP_CYC   = `GAP_MS * (`CLK_KHZ),
  parameter TEMP_LIM  = 85,
  parameter SPD_LIM   = 4500,
  parameter PULSE_LIM = 500
) (
  input  wire        i_core_clk,
  input  wire        i_srst,
  input  wire [7:0]  i_temp_c,
  input  wire [12:0] i_speed_rpm,
  input  wire [9:0]  i_pulse_khz,
  input  wire        i_over_torque,
  input  wire        i_overvolt,
  input  wire        i_undervolt,
  input  wire        i_dev_on,
  input  wire        i_dev_off,
  input  wire        i_op_data_bad,
  input  wire        i_gear_bad,
  input  wire        i_sensor_run,
  input  wire        i_sensor_init,
  input  wire        i_rotor_turn,
  input  wire        i_combo_bad,
  input  wire        i_stored_bad,
  input  wire        i_fault_clear_in,
  input  wire        i_ready,
  input  wire        i_torque_limit,
  input  wire        i_step_timing,
  input  wire [3:0]  i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [15:0] o_rdata,
  output reg         o_fault_flag_out,
  output reg         o_motor_stop,
  output reg         o_current_cut,
  output reg         o_ready_out,
  output reg         o_torque_limit_flag_out,
  output reg         o_step_timing_out,
  output reg  [6:0]  o_fault_code,
  output reg         o_fault_lamp,
  output reg         o_irq
);
  localparam N = `NUM_CAUSES;

  reg [N-1:0]  latched_reg;
  reg [N-1:0]  status_reg;
  reg [N-1:0]  mask_reg;
  reg [2:0]    ctrl_reg;
  reg [15:0]   ovl_limit_reg;
  reg [15:0]   ovl_acc_reg;
  reg          clr_in_d_reg;
  reg [6:0]    hist_reg [0:`HIST_DEPTH-1];
  reg [3:0]    hist_cnt_reg;
  // History bookkeeping: causes still waiting for a slot.
  reg [N-1:0]  pend_reg;
  reg [N-1:0]  pend_all;
  reg [N-1:0]  push_bit;
  reg [3:0]    push_idx;
  reg          have_push;
  reg [N-1:0]  raw;
  reg [N-1:0]  clr_mask;
  reg [3:0]    top_next;
  reg          have_top;
  reg [6:0]    code_of_top;
  reg [2:0]    bits_of_top;
  reg [3:0]    blinks_of_top;
  wire [N-1:0] rising = raw & ~latched_reg;
  wire         lamp;
  integer      i;
  integer      j;
  integer      k;

  // How a fault travels through this block:
  // a detector level is latched on the next edge and stays latched until a
  // clear that its cause permits; a cause still present at the clear is
  // latched again in the same cycle, so a clear never hides a live fault.
  // The reported cause is the lowest latched index, so a later fault of
  // higher priority takes over the code outputs and the lamp count.
  // The motor outputs are sums over all latched causes, not the reported one.
  // Outputs are all registered, so each lags its latch by one cycle; the lamp first lights one blink phase plus one cycle after its latch.
  //
  // Register map seen by the setup tool, one 16-bit word per address:
  //   0  sticky event status, cleared by its read
  //   1  interrupt mask, same layout as status
  //   2  control: code output enable, tool clear strobe, geared motor
  //   3  overload limit in cycles of load above maximum torque
  //   4  causes latched now
  //   5  history count on read, history clear on write
  //   6 to 15  history slots, newest first
  // A tool clear and a history clear act on the write cycle itself.
  // The history keeps codes, so two causes with one pattern still differ there.
  // Status and history both follow rising causes, never cleared ones.

  // Decimal fault code of one cause index; used for the history entries.
  // It must stay in step with the reported-code table further down.
  function [6:0] code_for;
    input [3:0] idx;
    begin
      case (idx)
        4'd0:    code_for = 7'd21;
        4'd1:    code_for = 7'd30;
        4'd2:    code_for = 7'd31;
        4'd3:    code_for = 7'd34;
        4'd4:    code_for = 7'd22;
        4'd5:    code_for = 7'd25;
        4'd6:    code_for = 7'd10;
        4'd7:    code_for = 7'd12;
        4'd8:    code_for = 7'd70;
        4'd9:    code_for = 7'd71;
        4'd10:   code_for = 7'd28;
        4'd11:   code_for = 7'd42;
        4'd12:   code_for = 7'd43;
        4'd13:   code_for = 7'd45;
        4'd14:   code_for = 7'd41;
        default: code_for = 7'd0;
      endcase
    end
  endfunction

  // Fault detectors, each a plain comparison or level.
  always @* begin
    raw = {N{1'b0}};
    raw[`C_OVERHEAT]    = i_temp_c > TEMP_LIM[7:0];
    raw[`C_OVERLOAD]    = ovl_acc_reg >= ovl_limit_reg;
    raw[`C_OVERSPEED]   = !ctrl_reg[`CTRL_GEARED] &&
                          (i_speed_rpm > SPD_LIM[12:0]);
    raw[`C_PULSE]       = i_pulse_khz > PULSE_LIM[9:0];
    raw[`C_OVERVOLT]    = i_overvolt;
    raw[`C_UNDERVOLT]   = i_undervolt;
    raw[`C_DEV_ON]      = i_dev_on;
    raw[`C_DEV_OFF]     = i_dev_off;
    raw[`C_OP_DATA]     = i_op_data_bad;
    raw[`C_GEAR]        = i_gear_bad;
    raw[`C_SENSOR_RUN]  = i_sensor_run;
    raw[`C_SENSOR_INIT] = i_sensor_init;
    raw[`C_ROTOR]       = i_rotor_turn;
    raw[`C_COMBO]       = i_combo_bad;
    raw[`C_STORED]      = i_stored_bad;
  end

  // A clear comes from the input's falling edge or the tool's write.
  wire clr_edge = clr_in_d_reg && !i_fault_clear_in;
  wire tool_clr = i_wr && (i_addr == `A_CTRL) &&
                  i_wdata[`CTRL_TOOL_CLR];
  always @* begin
    clr_mask = {N{1'b0}};
    if (clr_edge || tool_clr)
      clr_mask = ~`NORESET_MASK;
  end

  // Lowest index among latched faults names the reported cause.
  always @* begin
    top_next = 4'd0;
    have_top = 1'b0;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (latched_reg[i]) begin
        top_next = i[3:0];
        have_top = 1'b1;
      end
    end
  end

  // Code, 3-bit pattern and blink count of the reported cause.
  always @* begin
    code_of_top   = 7'd0;
    bits_of_top   = 3'b000;
    blinks_of_top = 4'd0;
    // Looked up from the current latch so code and flag change together.
    case (top_next)
      4'd0:  begin code_of_top = 7'd21; bits_of_top = 3'b010; end
      4'd1:  begin code_of_top = 7'd30; bits_of_top = 3'b010; end
      4'd2:  begin code_of_top = 7'd31; bits_of_top = 3'b010; end
      4'd3:  begin code_of_top = 7'd34; bits_of_top = 3'b010; end
      4'd4:  begin code_of_top = 7'd22; bits_of_top = 3'b011; end
      4'd5:  begin code_of_top = 7'd25; bits_of_top = 3'b011; end
      4'd6:  begin code_of_top = 7'd10; bits_of_top = 3'b100; end
      4'd7:  begin code_of_top = 7'd12; bits_of_top = 3'b100; end
      4'd8:  begin code_of_top = 7'd70; bits_of_top = 3'b111; end
      4'd9:  begin code_of_top = 7'd71; bits_of_top = 3'b111; end
      4'd10: begin code_of_top = 7'd28; bits_of_top = 3'b000; end
      4'd11: begin code_of_top = 7'd42; bits_of_top = 3'b000; end
      4'd12: begin code_of_top = 7'd43; bits_of_top = 3'b000; end
      4'd13: begin code_of_top = 7'd45; bits_of_top = 3'b000; end
      4'd14: begin code_of_top = 7'd41; bits_of_top = 3'b001; end
      default: begin code_of_top = 7'd0; bits_of_top = 3'b000; end
    endcase
    // Blink count follows the 3-bit group pattern.
    case (bits_of_top)
      3'b010:  blinks_of_top = 4'd2;
      3'b011:  blinks_of_top = 4'd3;
      3'b100:  blinks_of_top = 4'd4;
      3'b111:  blinks_of_top = 4'd7;
      3'b000:  blinks_of_top = 4'd8;
      3'b001:  blinks_of_top = 4'd9;
      default: blinks_of_top = 4'd0;
    endcase
  end

  // Latch faults; a fault present during a clear is raised again at once.
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      latched_reg  <= {N{1'b0}};
      clr_in_d_reg <= 1'b0;
    end else begin
      latched_reg  <= (latched_reg & ~clr_mask) | raw;
      clr_in_d_reg <= i_fault_clear_in;
    end
  end

  // Overload accumulator counts cycles of load above maximum torque.
  always @(posedge i_core_clk) begin
    if (i_srst || (latched_reg[`C_OVERLOAD] && clr_mask[`C_OVERLOAD]))
      ovl_acc_reg <= 16'h0_000;
    else if (i_over_torque && ovl_acc_reg != 16'hF_FFF)
      ovl_acc_reg <= ovl_acc_reg + 16'h0_001;
  end

  // Causes waiting to enter the history, one per cycle, lowest first.
  // Several faults can rise together; queuing them keeps each on record.
  // A cause that rises again while still queued is recorded only once.
  always @* begin
    pend_all  = pend_reg | rising;
    push_bit  = {N{1'b0}};
    push_idx  = 4'd0;
    have_push = 1'b0;
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (pend_all[k]) begin
        push_bit    = {N{1'b0}};
        push_bit[k] = 1'b1;
        push_idx    = k[3:0];
        have_push   = 1'b1;
      end
    end
  end

  // Fault history: newest in slot 0, older entries move down one slot.
  // The count stops at the depth; the oldest entry then falls off.
  always @(posedge i_core_clk) begin
    if (i_srst || (i_wr && i_addr == `A_HIST_CLR)) begin
      hist_cnt_reg <= 4'd0;
      pend_reg     <= {N{1'b0}};
      for (j = 0; j < `HIST_DEPTH; j = j + 1)
        hist_reg[j] <= 7'd0;
    end else begin
      pend_reg <= pend_all & ~push_bit;
      if (have_push) begin
        hist_reg[0] <= code_for(push_idx);
        for (j = 1; j < `HIST_DEPTH; j = j + 1)
          hist_reg[j] <= hist_reg[j-1];
        if (hist_cnt_reg != 4'd`HIST_DEPTH)
          hist_cnt_reg <= hist_cnt_reg + 4'd1;
      end
    end
  end

  // Plant outputs.
  // Pin remapping is registered here so outputs stay flip-flop driven.
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_fault_flag_out        <= 1'b1;
      o_motor_stop            <= 1'b0;
      o_current_cut           <= 1'b0;
      o_ready_out             <= 1'b0;
      o_torque_limit_flag_out <= 1'b0;
      o_step_timing_out       <= 1'b0;
      o_fault_code            <= 7'd0;
      o_fault_lamp            <= 1'b0;
    end else begin
      o_fault_flag_out <= !(|latched_reg);
      // Only operation data fault leaves the motor running.
      o_motor_stop  <= |(latched_reg & ~(1 << `C_OP_DATA));
      o_current_cut <= |(latched_reg & `CUT_MASK);
      o_fault_code  <= have_top ? code_of_top : 7'd0;
      o_fault_lamp  <= lamp;
      if (ctrl_reg[`CTRL_CODE_EN]) begin
        o_ready_out             <= (|latched_reg) & bits_of_top[0];
        o_torque_limit_flag_out <= (|latched_reg) & bits_of_top[1];
        o_step_timing_out       <= (|latched_reg) & bits_of_top[2];
      end else begin
        o_ready_out             <= i_ready;
        o_torque_limit_flag_out <= i_torque_limit;
        o_step_timing_out       <= i_step_timing;
      end
    end
  end

  blink_counter #(
    .PHASE_CYC (PHASE_CYC),
    .GAP_CYC   (GAP_CYC)
  ) u_blink (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_run      (|latched_reg),
    .i_count    (blinks_of_top),
    .o_lamp     (lamp)
  );

  // Software registers; status is sticky and cleared by its read.
  // A new event in the read cycle survives the clear.
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      status_reg    <= {N{1'b0}};
      mask_reg      <= {N{1'b0}};
      ctrl_reg      <= 3'b000;
      ovl_limit_reg <= `OVL_LIMIT_RST;
      o_rdata       <= 16'h0_000;
      o_irq         <= 1'b0;
    end else begin
      status_reg <= ((i_rd && i_addr == `A_STATUS) ? {N{1'b0}}
                     : status_reg) | rising;
      o_irq      <= |(status_reg & mask_reg);
      if (i_wr) begin
        case (i_addr)
          `A_MASK:      mask_reg      <= i_wdata[N-1:0];
          `A_CTRL:      ctrl_reg      <= {i_wdata[2], 1'b0, i_wdata[0]};
          `A_OVL_LIMIT: ovl_limit_reg <= i_wdata;
          default:      ;
        endcase
      end
      o_rdata <= 16'h0_000;
      if (i_rd) begin
        case (i_addr)
          `A_STATUS:    o_rdata <= {1'b0, status_reg};
          `A_MASK:      o_rdata <= {1'b0, mask_reg};
          `A_CTRL:      o_rdata <= {13'd0, ctrl_reg};
          `A_OVL_LIMIT: o_rdata <= ovl_limit_reg;
          `A_ACTIVE:    o_rdata <= {1'b0, latched_reg};
          `A_HIST_CLR:  o_rdata <= {12'd0, hist_cnt_reg};
          default: begin
            if (i_addr >= `A_HIST_BASE)
              o_rdata <= {9'd0, hist_reg[i_addr - `A_HIST_BASE]};
          end
        endcase
      end
    end
  end
endmodule

// ==== tb/fault_mgr_properties.sv ====
// Purpose: Port assertions for the motor driver fault manager.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Up to three cycles are allowed from a cause to the outputs.
`timescale 1ns/100ps
module fault_mgr_properties (
  input wire       i_core_clk,
  input wire       i_srst,
  input wire [7:0] i_temp_c,
  input wire [9:0] i_pulse_khz,
  input wire       i_dev_on,
  input wire       i_fault_clear_in,
  input wire       o_fault_flag_out,
  input wire       o_motor_stop,
  input wire       o_current_cut,
  input wire [6:0] o_fault_code,
  input wire       o_fault_lamp
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);
  // The ON edge of a clear while a fault shows; only OFF may clear.
  sequence clr_rise;
    $rose(i_fault_clear_in) ##0 !o_fault_flag_out;
  endsequence
  // Several cycles with no fault shown.
  sequence all_quiet;
    o_fault_flag_out [*3];
  endsequence
  flag_drop_a:
    assert property (i_dev_on |-> ##[1:3] !o_fault_flag_out)
    else $error("fault flag did not drop");
  overheat_a:
    assert property (i_temp_c > 8'h55 |-> ##[1:3] !o_fault_flag_out)
    else $error("overheat not raised");
  pulse_cut_a:
    assert property (i_pulse_khz > 10'h1F4 |-> ##[1:3] o_current_cut)
    else $error("pulse fault kept current");
  stop_any_a:
    assert property (!o_fault_flag_out |-> o_motor_stop ||
                     o_fault_code == 7'h46)
    else $error("fault without stop");
  cut_any_a:
    assert property (!o_fault_flag_out && o_fault_code != 7'h46 |->
                     o_current_cut)
    else $error("cutting fault kept current");
  rise_hold_a:
    assert property (clr_rise |=> !o_fault_flag_out)
    else $error("clear acted on ON edge");
  sensor_hold_a:
    assert property (o_fault_code == 7'h1C && !o_fault_flag_out |=>
                     !o_fault_flag_out)
    else $error("sensor fault cleared");
  overvolt_hold_a:
    assert property (o_fault_code == 7'h16 && !o_fault_flag_out |=>
                     !o_fault_flag_out)
    else $error("overvoltage cleared");
  lamp_idle_a:
    assert property (all_quiet |-> !o_fault_lamp)
    else $error("lamp lit with no fault");
endmodule

bind motor_driver_fault_manager fault_mgr_properties chk (
  .i_core_clk, .i_srst, .i_temp_c, .i_pulse_khz, .i_dev_on,
  .i_fault_clear_in, .o_fault_flag_out, .o_motor_stop, .o_current_cut,
  .o_fault_code, .o_fault_lamp
);

// ==== tb/host_ctrl_model.sv ====
// Purpose: Host controller that drives clear and the pulse rate.
// Assumes: A clear request is one cycle long.
// Notes:   Clear stays ON two cycles so the OFF edge is clean.
`timescale 1ns/100ps
module host_ctrl_model (
  input  wire       i_core_clk,
  input  wire       i_clear_go,
  input  wire       i_over_rate,
  output reg        o_clear,
  output wire [9:0] o_pulse_khz
);
  reg [1:0] hold_reg;
  // Rate sits at the ceiling unless a test asks to exceed it.
  assign o_pulse_khz = i_over_rate ? 10'h1F5 : 10'h1F4;
  // Clear starts OFF.
  initial begin
    o_clear = 1'b0;
    hold_reg = 2'h0;
  end
  // ON, then OFF two cycles later.
  always @(posedge i_core_clk) begin
    if (i_clear_go) begin
      o_clear <= 1'b1;
      hold_reg <= 2'h2;
    end else if (hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
      o_clear <= (hold_reg != 2'h1);
    end
  end
endmodule

// ==== tb/motor_driver_fault_manager_tb.sv ====
// Purpose: Self-checking bench for the motor driver fault manager.
// Assumes: Blink phases shortened to 4 and 16 cycles.
// Notes:   A power cycle between tests removes unclearable faults.
`timescale 1ns/100ps
module motor_driver_fault_manager_tb;
  reg         clk, srst, go, rdy, wr, rd;
  reg  [14:0] cause;
  reg  [3:0]  addr;
  reg  [15:0] wdata, d;
  reg  [9:0]  tab [0:14];
  wire [15:0] rdata;
  wire [9:0]  pulse;
  wire [6:0]  code;
  wire        flag, stop, cut, r_o, t_o, s_o, lamp, irq, clr;
  integer     failures, n_checks, i, n, k;

  motor_driver_fault_manager #(.PHASE_CYC(4), .GAP_CYC(16)) dut (
    .i_core_clk(clk), .i_srst(srst), .i_temp_c(cause[0] ? 8'h56 : 8'h55),
    .i_speed_rpm(cause[2] ? 13'h1195 : 13'h1194), .i_pulse_khz(pulse),
    .i_over_torque(cause[1]), .i_overvolt(cause[4]),
    .i_undervolt(cause[5]), .i_dev_on(cause[6]), .i_dev_off(cause[7]),
    .i_op_data_bad(cause[8]), .i_gear_bad(cause[9]),
    .i_sensor_run(cause[10]), .i_sensor_init(cause[11]),
    .i_rotor_turn(cause[12]), .i_combo_bad(cause[13]),
    .i_stored_bad(cause[14]), .i_fault_clear_in(clr), .i_ready(rdy),
    .i_torque_limit(~rdy), .i_step_timing(rdy), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_fault_flag_out(flag), .o_motor_stop(stop), .o_current_cut(cut),
    .o_ready_out(r_o), .o_torque_limit_flag_out(t_o),
    .o_step_timing_out(s_o), .o_fault_code(code), .o_fault_lamp(lamp),
    .o_irq(irq));
  host_ctrl_model host (.i_core_clk(clk), .i_clear_go(go),
    .i_over_rate(cause[3]), .o_clear(clr), .o_pulse_khz(pulse));

  // Free-running core clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Watchdog far beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    failures = failures + 1;
    wrap_up;
  end
  task wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task tick(input integer c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task check(input [15:0] got, input [15:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  // One-cycle bus strobe; a read returns data the cycle after.
  task bus(input w, input [3:0] a, input [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task power;
    @(posedge clk);
    srst <= 1'b1;
    cause <= 15'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
  endtask
  task raise(input [14:0] c);
    @(posedge clk);
    cause <= c;
    tick(8);
    @(posedge clk);
    cause <= 15'h0;
    tick(2);
  endtask
  task pulse_clear;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    tick(1);
    check(flag, 1'b0);
    tick(8);
  endtask
  // Every cause in turn, with code outputs on and a short limit.
  task t_codes;
    for (i = 0; i < 15; i = i + 1) begin
      power;
      bus(1'b1, 4'h2, 16'h0001);
      bus(1'b1, 4'h3, 16'h0004);
      raise(15'h0001 << i);
      check(flag, 1'b0);
      check(code, tab[i][6:0]);
      check({s_o, t_o, r_o}, tab[i][9:7]);
      check(cut, i != 8);
      check(stop, i != 8);
    end
    $display("codes done");
  endtask
  task t_clear;
    power;
    raise(15'h0040);
    pulse_clear;
    check(flag, 1'b1);
    raise(15'h0010);
    pulse_clear;
    check(flag, 1'b0);
    bus(1'b1, 4'h2, 16'h0002);
    tick(4);
    check(flag, 1'b0);
    power;
    bus(1'b1, 4'h2, 16'h0004);
    raise(15'h0004);
    check(flag, 1'b1);
    @(posedge clk);
    cause <= 15'h0080;
    pulse_clear;
    check(flag, 1'b0);
    $display("clear done");
  endtask
  task t_irq;
    power;
    raise(15'h0001);
    check(irq, 1'b0);
    bus(1'b1, 4'h1, 16'h7FFF);
    tick(3);
    check(irq, 1'b1);
    bus(1'b0, 4'h0, 16'h0000);
    check(d, 16'h0001);
    tick(3);
    check(irq, 1'b0);
    bus(1'b0, 4'h5, 16'h0000);
    check(d, 16'h0001);
    bus(1'b0, 4'h6, 16'h0000);
    check(d, 16'h0015);
    bus(1'b1, 4'h5, 16'h0000);
    bus(1'b0, 4'h5, 16'h0000);
    check(d, 16'h0000);
    $display("irq done");
  endtask
  // Overvoltage: wait inside the long gap, then count one burst.
  task t_lamp;
    power;
    raise(15'h0010);
    k = 0;
    n = 0;
    while (n < 8 && k < 200) begin
      n = (lamp === 1'b0) ? n + 1 : 0;
      tick(1);
      k = k + 1;
    end
    n = 0;
    for (k = 0; k < 40; k = k + 1) begin
      d[0] = lamp;
      tick(1);
      if (!d[0] && lamp === 1'b1)
        n = n + 1;
    end
    check(n[15:0], 16'h0003);
    $display("lamp done");
  endtask
  // Table entries are {3-bit pattern, 7-bit code} in cause order.
  initial begin
    tab = '{10'h115, 10'h11E, 10'h11F, 10'h122, 10'h196, 10'h199,
            10'h20A, 10'h20C, 10'h3C6, 10'h3C7, 10'h01C, 10'h02A,
            10'h02B, 10'h02D, 10'h0A9};
    failures = 0;
    n_checks = 0;
    {srst, go, rdy, wr, rd} = 5'h14;
    {cause, addr, wdata} = 35'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    tick(2);
    check(flag, 1'b1);
    check({s_o, t_o, r_o}, 3'h5);
    t_codes;
    t_clear;
    t_irq;
    t_lamp;
    wrap_up;
  end
endmodule
